// file: src/csd_pkg.sv
// Constants, address map and helpers for the configuration space decoder.
// Assumes a 24-bit system bus address and an 8-bit host I/O data path.
// Overview of operation
// - Config registers live at frame offsets 300h-3FFh
// - Embedded controller may use byte, halfword, word accesses
// - Host configuration accesses are byte wide only
// - LPC unit configuration decoded at FF_3300h-FF_33F0h
// - Fixed unit numbers for every basechip unit
// - Host reaches configuration registers only through ports
// - Embedded controller reaches every register by address; FFFF04h-FFFF07h go to the unit select decode, not the bus
// - Companion adds up to sixteen further units
// - Basechip at FF page, companion at FE page
// - Access width limited by register width
// - Host sees every register as bytes
// - Global unit window register: only valid bit writable
// - LPC unit FF_3000h, global unit FF_FC00h
// - Key, select at offset 0; value at 1
// - Host ports invisible to the embedded controller
// - Host port location set by window register
// - 55h enters configuration state, AAh leaves it
// - Select and value ports ignored in run state
// - Index 07h selects unit; upper indexes route there
// - Undefined indexes read FFh, writes change nothing
package csd_pkg;
    localparam logic [7:0]  KEY_ENTER     = 8'h55;
    localparam logic [7:0]  KEY_EXIT      = 8'hAA;
    localparam logic [7:0]  IDX_UNIT_SEL  = 8'h07;
    localparam logic [7:0]  GLOBAL_LIMIT  = 8'h30;
    localparam logic [7:0]  UNDEF_READ    = 8'hFF;
    localparam logic [7:0]  INDEX_RESET   = 8'h00;
    localparam logic        PORT_VALUE    = 1'b1;
    localparam int          UNIT_W        = 7;
    localparam int          UNIT_COMP_BIT = 6;
    localparam logic [6:0]  UNIT_RESET    = 7'h00;
    localparam logic [7:0]  BASECHIP_PAGE = 8'hFF;
    localparam logic [7:0]  COMP_PAGE     = 8'hFE;
    localparam logic [1:0]  COMP_PAD      = 2'h0;
    localparam logic [1:0]  QUAD_CFG      = 2'h3;
    localparam logic [23:0] LPC_UNIT_BASE = 24'hFF3000;
    localparam logic [23:0] GLOB_UNIT_BASE = 24'hFFFC00;
    localparam logic [23:0] LPC_CFG_LO    = 24'hFF3300;
    localparam logic [23:0] LPC_CFG_HI    = 24'hFF33F0;
    localparam logic [23:0] PORT_BAR_ADDR = 24'hFF3360;
    localparam logic [23:0] GLOB_BAR_ADDR = 24'hFF3384;
    localparam logic [23:0] UNIT_SEL_WORD = 24'hFFFF04;
    localparam int          UNIT_SEL_LANE = 3;
    localparam int          UNIT_SEL_SHIFT = 24;
    localparam int          BAR_VALID_BIT = 31;
    localparam logic [31:0] BAR_RESET     = 32'h00000000;
    localparam logic [1:0]  SZ_BYTE       = 2'h0;
    localparam logic [1:0]  SZ_HALF       = 2'h1;
    localparam logic [1:0]  SZ_WORD       = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HOST = 2'h1,
        ST_EC   = 2'h3,
        ST_DONE = 2'h2
    } csd_state_e;

    // Byte lanes of an aligned access; none when misaligned
    function automatic logic [3:0] csd_lanes(input logic [1:0] size, input logic [1:0] a);
        logic [3:0] r;
        r = 4'h0;
        case (size)
            SZ_BYTE: r = 4'h1 << a;
            SZ_HALF: r = a[0] ? 4'h0 : (a[1] ? 4'hC : 4'h3);
            SZ_WORD: r = (a == 2'h0) ? 4'hF : 4'h0;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // Units that answer on the basechip or companion page
    function automatic logic csd_unit_known(input logic [6:0] u);
        if (u[UNIT_COMP_BIT])
            return u[5:4] == COMP_PAD;
        return (u <= 7'h08) || (u >= 7'h0C && u <= 7'h10) || (u == 7'h3F);
    endfunction
endpackage

// file: src/csd_sel_if.sv
// Carrier between the decoder and its configuration state holder.
// Assumes one owner and one user in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface csd_sel_if;
    logic       cfg_mode;
    logic [7:0] index;
    logic [6:0] unit;
    logic       key_we;
    logic [7:0] key_data;
    logic       unit_we;
    logic [6:0] unit_data;
    modport owner (input key_we, key_data, unit_we, unit_data,
                   output cfg_mode, index, unit);
    modport user  (output key_we, key_data, unit_we, unit_data,
                   input cfg_mode, index, unit);
endinterface
`default_nettype wire

// file: src/csd_cfg_state.sv
// Run/configuration state, select index and unit number holder.
// Assumes write strobes are single-cycle pulses from the decoder.
`timescale 1ns/1ps
`default_nettype none
module csd_cfg_state (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    csd_sel_if.owner  sel
);
    logic       mode;
    logic       next_mode;
    logic [7:0] index;
    logic [7:0] next_index;
    logic [6:0] unit;
    logic [6:0] next_unit;

    always_comb begin
        next_mode  = mode;
        next_index = index;
        next_unit  = unit;
        if (sel.key_we) begin
            if (!mode) begin
                next_mode = (sel.key_data == csd_pkg::KEY_ENTER);
            end else if (sel.key_data == csd_pkg::KEY_EXIT) begin
                next_mode = 1'b0;
            end else begin
                next_index = sel.key_data;
            end
        end
        if (sel.unit_we) begin
            next_unit = sel.unit_data;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode  <= 1'b0;
            index <= csd_pkg::INDEX_RESET;
            unit  <= csd_pkg::UNIT_RESET;
        end else begin
            mode  <= next_mode;
            index <= next_index;
            unit  <= next_unit;
        end
    end

    assign sel.cfg_mode = mode;
    assign sel.index    = index;
    assign sel.unit     = unit;
endmodule // csd_cfg_state
`default_nettype wire

// file: src/csd_bar_bank.sv
// Window registers in the LPC unit configuration range.
// Assumes the decoder presents word offsets and byte lanes of one access.
`timescale 1ns/1ps
`default_nettype none
module csd_bar_bank (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  word_i,
    input  wire logic [3:0]  strb_i,
    input  wire logic [31:0] wdata_i,
    output logic      [31:0] rdata_o,
    output logic      [15:0] port_base_o,
    output logic             port_valid_o
);
    localparam logic [5:0] PORT_WORD = csd_pkg::PORT_BAR_ADDR[7:2];
    localparam logic [5:0] GLOB_WORD = csd_pkg::GLOB_BAR_ADDR[7:2];
    logic [31:0] port_bar;
    logic [31:0] next_port_bar;
    logic        glob_valid;
    logic        next_glob_valid;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign next_port_bar[8*g +: 8] = (we_i && word_i == PORT_WORD && strb_i[g])
                                             ? wdata_i[8*g +: 8] : port_bar[8*g +: 8];
        end
    endgenerate

    // Global window is fixed; only its valid bit takes a write
    always_comb begin
        next_glob_valid = glob_valid;
        if (we_i && word_i == GLOB_WORD && strb_i[csd_pkg::BAR_VALID_BIT / 8]) begin
            next_glob_valid = wdata_i[csd_pkg::BAR_VALID_BIT];
        end
        rdata_o = 32'h0;
        if (word_i == PORT_WORD) begin
            rdata_o = port_bar;
        end else if (word_i == GLOB_WORD) begin
            rdata_o[csd_pkg::BAR_VALID_BIT] = glob_valid;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            port_bar   <= csd_pkg::BAR_RESET;
            glob_valid <= 1'b0;
        end else begin
            port_bar   <= next_port_bar;
            glob_valid <= next_glob_valid;
        end
    end

    assign port_base_o  = port_bar[15:0];
    assign port_valid_o = port_bar[csd_pkg::BAR_VALID_BIT];
endmodule // csd_bar_bank
`default_nettype wire

// file: src/csd_decoder.sv
// Configuration space decoder: host key/select/value ports and
// embedded controller direct access, both onto the peripheral bus.
// Assumes requesters hold valid until their done pulse, then drop it.
`timescale 1ns/1ps
`default_nettype none
module csd_decoder (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Host I/O cycles
    input  wire logic        hio_valid_i,
    input  wire logic        hio_write_i,
    input  wire logic [15:0] hio_addr_i,
    input  wire logic [7:0]  hio_wdata_i,
    output logic             hio_claim_o,
    output logic             hio_done_o,
    output logic      [7:0]  hio_rdata_o,
    // Embedded controller
    input  wire logic        ec_valid_i,
    input  wire logic        ec_write_i,
    input  wire logic [1:0]  ec_size_i,
    input  wire logic [23:0] ec_addr_i,
    input  wire logic [31:0] ec_wdata_i,
    output logic             ec_done_o,
    output logic             ec_err_o,
    output logic      [31:0] ec_rdata_o,
    // Peripheral bus toward the units
    output logic             pb_valid_o,
    output logic             pb_write_o,
    output logic      [23:0] pb_addr_o,
    output logic      [3:0]  pb_strb_o,
    output logic      [31:0] pb_wdata_o,
    input  wire logic [31:0] pb_rdata_i,
    input  wire logic        pb_done_i,
    input  wire logic        pb_err_i,
    // Status
    output logic             cfg_mode_o
);
    csd_sel_if sel ();

    csd_cfg_state u_state (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .sel    (sel.owner)
    );

    logic [31:0] bar_rdata;
    logic [15:0] port_base;
    logic        port_valid;
    logic        bar_we;
    logic [3:0]  ec_lanes;

    csd_bar_bank u_bars (
        .clk_i        (clk_i),
        .nrst_i       (nrst_i),
        .we_i         (bar_we),
        .word_i       (ec_addr_i[7:2]),
        .strb_i       (ec_lanes),
        .wdata_i      (ec_wdata_i),
        .rdata_o      (bar_rdata),
        .port_base_o  (port_base),
        .port_valid_o (port_valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Host side decode

    logic        value_port;
    logic [23:0] host_addr;
    logic        host_route_ok;
    logic [3:0]  host_lanes;

    // Two-byte window; base bit 0 is ignored
    assign hio_claim_o = hio_valid_i && port_valid
                         && (hio_addr_i[15:1] == port_base[15:1]);
    assign value_port  = (hio_addr_i[0] == csd_pkg::PORT_VALUE);
    assign cfg_mode_o  = sel.cfg_mode;

    always_comb begin
        host_route_ok = 1'b1;
        if (sel.index < csd_pkg::GLOBAL_LIMIT) begin
            host_addr = {csd_pkg::GLOB_UNIT_BASE[23:10], csd_pkg::QUAD_CFG, sel.index};
        end else if (sel.unit[csd_pkg::UNIT_COMP_BIT]) begin
            host_addr = {csd_pkg::COMP_PAGE, csd_pkg::COMP_PAD, sel.unit[3:0],
                         csd_pkg::QUAD_CFG, sel.index};
        end else begin
            host_addr = {csd_pkg::BASECHIP_PAGE, sel.unit[5:0],
                         csd_pkg::QUAD_CFG, sel.index};
        end
        if (!csd_pkg::csd_unit_known(sel.unit) && sel.index >= csd_pkg::GLOBAL_LIMIT) begin
            host_route_ok = 1'b0;
        end
        host_lanes = csd_pkg::csd_lanes(csd_pkg::SZ_BYTE, sel.index[1:0]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Embedded controller side decode

    logic       ec_in_map;
    logic       ec_lpc_hit;
    logic       ec_usel_hit;

    always_comb begin
        ec_lanes    = csd_pkg::csd_lanes(ec_size_i, ec_addr_i[1:0]);
        ec_in_map   = (ec_addr_i[23:16] == csd_pkg::BASECHIP_PAGE)
                      || (ec_addr_i[23:16] == csd_pkg::COMP_PAGE);
        ec_lpc_hit  = (ec_addr_i[23:2] >= csd_pkg::LPC_CFG_LO[23:2])
                      && (ec_addr_i[23:2] <= csd_pkg::LPC_CFG_HI[23:2]);
        ec_usel_hit = (ec_addr_i[23:2] == csd_pkg::UNIT_SEL_WORD[23:2]);
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    csd_pkg::csd_state_e state;
    csd_pkg::csd_state_e next_state;
    logic        next_pb_valid;
    logic        next_pb_write;
    logic [23:0] next_pb_addr;
    logic [3:0]  next_pb_strb;
    logic [31:0] next_pb_wdata;
    logic        next_hio_done;
    logic [7:0]  next_hio_rdata;
    logic        next_ec_done;
    logic        next_ec_err;
    logic [31:0] next_ec_rdata;
    logic [1:0]  host_lane;

    assign host_lane = pb_addr_o[1:0];

    always_comb begin
        next_state     = state;
        next_pb_valid  = pb_valid_o;
        next_pb_write  = pb_write_o;
        next_pb_addr   = pb_addr_o;
        next_pb_strb   = pb_strb_o;
        next_pb_wdata  = pb_wdata_o;
        next_hio_done  = 1'b0;
        next_hio_rdata = hio_rdata_o;
        next_ec_done   = 1'b0;
        next_ec_err    = 1'b0;
        next_ec_rdata  = ec_rdata_o;
        sel.key_we     = 1'b0;
        sel.key_data   = hio_wdata_i;
        sel.unit_we    = 1'b0;
        sel.unit_data  = hio_wdata_i[csd_pkg::UNIT_W-1:0];
        bar_we         = 1'b0;
        case (state)
            csd_pkg::ST_IDLE: begin
                // Host wins a tie; the controller simply waits a turn
                if (hio_claim_o) begin
                    next_state     = csd_pkg::ST_DONE;
                    next_hio_done  = 1'b1;
                    next_hio_rdata = csd_pkg::UNDEF_READ;
                    if (!value_port) begin
                        if (hio_write_i) begin
                            sel.key_we = 1'b1;
                        end else if (sel.cfg_mode) begin
                            next_hio_rdata = sel.index;
                        end
                    end else if (!sel.cfg_mode) begin
                        next_hio_rdata = csd_pkg::UNDEF_READ;
                    end else if (sel.index == csd_pkg::IDX_UNIT_SEL) begin
                        sel.unit_we    = hio_write_i;
                        next_hio_rdata = 8'(sel.unit);
                    end else if (host_route_ok) begin
                        next_state    = csd_pkg::ST_HOST;
                        next_hio_done = 1'b0;
                        next_pb_valid = 1'b1;
                        next_pb_write = hio_write_i;
                        next_pb_addr  = host_addr;
                        next_pb_strb  = host_lanes;
                        next_pb_wdata = {4{hio_wdata_i}};
                    end
                end else if (ec_valid_i) begin
                    next_state    = csd_pkg::ST_DONE;
                    next_ec_done  = 1'b1;
                    next_ec_rdata = 32'h0;
                    // Host ports have no bus address of their own
                    if (ec_lanes == 4'h0 || !ec_in_map) begin
                        next_ec_err = 1'b1;
                    end else if (ec_lpc_hit) begin
                        bar_we        = ec_write_i;
                        next_ec_rdata = bar_rdata;
                    end else if (ec_usel_hit) begin
                        sel.unit_we   = ec_write_i && ec_lanes[csd_pkg::UNIT_SEL_LANE];
                        sel.unit_data = ec_wdata_i[csd_pkg::UNIT_SEL_SHIFT +: csd_pkg::UNIT_W];
                        next_ec_rdata = 32'(sel.unit) << csd_pkg::UNIT_SEL_SHIFT;
                    end else begin
                        next_state    = csd_pkg::ST_EC;
                        next_ec_done  = 1'b0;
                        next_pb_valid = 1'b1;
                        next_pb_write = ec_write_i;
                        next_pb_addr  = ec_addr_i;
                        next_pb_strb  = ec_lanes;
                        next_pb_wdata = ec_wdata_i;
                    end
                end
            end
            csd_pkg::ST_HOST: begin
                if (pb_done_i) begin
                    next_state     = csd_pkg::ST_DONE;
                    next_pb_valid  = 1'b0;
                    next_hio_done  = 1'b1;
                    // Failed write still completes; failed read shows FFh
                    next_hio_rdata = pb_err_i ? csd_pkg::UNDEF_READ
                                              : pb_rdata_i[{host_lane, 3'h0} +: 8];
                end
            end
            csd_pkg::ST_EC: begin
                if (pb_done_i) begin
                    next_state    = csd_pkg::ST_DONE;
                    next_pb_valid = 1'b0;
                    next_ec_done  = 1'b1;
                    next_ec_err   = pb_err_i;
                    next_ec_rdata = pb_rdata_i;
                end
            end
            default: begin
                // Gap cycle lets the requester drop valid
                next_state = csd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state       <= csd_pkg::ST_IDLE;
            pb_valid_o  <= 1'b0;
            pb_write_o  <= 1'b0;
            pb_addr_o   <= 24'h0;
            pb_strb_o   <= 4'h0;
            pb_wdata_o  <= 32'h0;
            hio_done_o  <= 1'b0;
            hio_rdata_o <= 8'h0;
            ec_done_o   <= 1'b0;
            ec_err_o    <= 1'b0;
            ec_rdata_o  <= 32'h0;
        end else begin
            state       <= next_state;
            pb_valid_o  <= next_pb_valid;
            pb_write_o  <= next_pb_write;
            pb_addr_o   <= next_pb_addr;
            pb_strb_o   <= next_pb_strb;
            pb_wdata_o  <= next_pb_wdata;
            hio_done_o  <= next_hio_done;
            hio_rdata_o <= next_hio_rdata;
            ec_done_o   <= next_ec_done;
            ec_err_o    <= next_ec_err;
            ec_rdata_o  <= next_ec_rdata;
        end
    end
endmodule // csd_decoder
`default_nettype wire

// file: dv/csd_pb_model.sv
// Peripheral bus units: byte-lane memory that answers after a set delay.
// Assumes the decoder holds each request until it has seen done.
`timescale 1ns/1ps
`default_nettype none
module csd_pb_model (
    input  wire logic        clk_i,
    input  wire logic [3:0]  dly_i,
    input  wire logic        pb_valid_i,
    input  wire logic        pb_write_i,
    input  wire logic [23:0] pb_addr_i,
    input  wire logic [3:0]  pb_strb_i,
    input  wire logic [31:0] pb_wdata_i,
    output logic      [31:0] pb_rdata_o,
    output logic             pb_done_o,
    output logic             pb_err_o
);
    logic [31:0] mem [0:255];
    logic [3:0]  cnt;
    initial begin
        pb_rdata_o = '0;
        pb_done_o = 1'b0;
        pb_err_o = 1'b0;
        cnt = '0;
        foreach (mem[k]) mem[k] = '0;
    end
    always @(posedge clk_i) begin
        pb_done_o <= 1'b0;
        pb_err_o <= 1'b0;
        // Stale read data changes every cycle, never held
        pb_rdata_o <= ~pb_rdata_o;
        if (pb_valid_i && !pb_done_o) begin
            cnt <= cnt + 4'h1;
            if (cnt >= dly_i) begin
                cnt <= '0;
                pb_done_o <= 1'b1;
                // Unit 0Dh faults every access, to reach the error path
                pb_err_o <= pb_addr_i[15:10] == 6'h0D;
                if (!pb_write_i)
                    pb_rdata_o <= mem[pb_addr_i[9:2]];
                for (int b = 0; b < 4; b++)
                    if (pb_write_i && pb_strb_i[b])
                        mem[pb_addr_i[9:2]][8*b +: 8] <= pb_wdata_i[8*b +: 8];
            end
        end
    end
endmodule // csd_pb_model
`default_nettype wire

// file: dv/csd_decoder_checker.sv
// Concurrent checks on the decoder's ports.
// Assumes it is bound onto csd_decoder; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module csd_decoder_checker (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        hio_valid_i,
    input wire logic        hio_claim_o,
    input wire logic        hio_done_o,
    input wire logic        ec_done_o,
    input wire logic        ec_err_o,
    input wire logic        pb_valid_o,
    input wire logic [23:0] pb_addr_o,
    input wire logic [3:0]  pb_strb_o,
    input wire logic        pb_done_i,
    input wire logic        cfg_mode_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    claim_needs_cycle_a: assert property (hio_claim_o |-> hio_valid_i)
        else $error("claim without host cycle");
    host_done_pulse_a: assert property (hio_done_o |=> !hio_done_o)
        else $error("host done longer than one cycle");
    ec_done_pulse_a: assert property (ec_done_o |=> !ec_done_o)
        else $error("controller done longer than one cycle");
    ec_err_done_a: assert property (ec_err_o |-> ec_done_o)
        else $error("controller error without done");
    pb_hold_a: assert property (pb_valid_o && !pb_done_i |=> pb_valid_o && $stable(pb_addr_o))
        else $error("bus request changed before done");
    pb_page_a: assert property (pb_valid_o |-> pb_addr_o[23:16] inside {8'hFF, 8'hFE})
        else $error("bus request outside both pages");
    pb_lanes_a: assert property (pb_valid_o |-> pb_strb_o inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF})
        else $error("bus strobes not an aligned lane set");
    pb_answer_a: assert property (pb_valid_o && pb_done_i |=> !pb_valid_o && (hio_done_o || ec_done_o))
        else $error("bus done not passed on next cycle");
    mode_on_key_a: assert property ($changed(cfg_mode_o) |-> hio_done_o)
        else $error("state changed outside a host write");
endmodule // csd_decoder_checker
bind csd_decoder csd_decoder_checker u_chk (.clk_i, .nrst_i, .hio_valid_i, .hio_claim_o, .hio_done_o,
    .ec_done_o, .ec_err_o, .pb_valid_o, .pb_addr_o, .pb_strb_o, .pb_done_i, .cfg_mode_o);
`default_nettype wire

// file: dv/tb_csd_decoder.sv
// Testbench for the configuration space decoder: host ports and controller access.
// Assumes host port window at 002Eh, programmed by the controller first.
`timescale 1ns/1ps
`default_nettype none
module tb_csd_decoder;
    logic        clk_i = 1'b0, nrst_i = 1'b0;
    logic        hio_valid_i = 1'b0, hio_write_i = 1'b0, ec_valid_i = 1'b0, ec_write_i = 1'b0;
    logic [15:0] hio_addr_i = '0;
    logic [7:0]  hio_wdata_i = '0, hio_rdata_o, hr;
    logic [1:0]  ec_size_i = '0;
    logic [23:0] ec_addr_i = '0, pb_addr_o, last_a;
    logic [31:0] ec_wdata_i = '0, ec_rdata_o, pb_wdata_o, pb_rdata_i, rd;
    logic [3:0]  pb_strb_o, last_s, dly = 4'h2;
    logic        hio_claim_o, hio_done_o, ec_done_o, ec_err_o, pb_valid_o, pb_write_o;
    logic        pb_done_i, pb_err_i, cfg_mode_o, er;
    logic [25:0] bad [3] = '{{2'h1, 24'hFF3361}, {2'h3, 24'hFF3360}, {2'h2, 24'hF00000}};
    int          n_fail = 0, comparisons = 0;
    csd_decoder DUT (.clk_i, .nrst_i, .hio_valid_i, .hio_write_i, .hio_addr_i, .hio_wdata_i,
        .hio_claim_o, .hio_done_o, .hio_rdata_o, .ec_valid_i, .ec_write_i, .ec_size_i, .ec_addr_i,
        .ec_wdata_i, .ec_done_o, .ec_err_o, .ec_rdata_o, .pb_valid_o, .pb_write_o, .pb_addr_o,
        .pb_strb_o, .pb_wdata_o, .pb_rdata_i, .pb_done_i, .pb_err_i, .cfg_mode_o);
    csd_pb_model u_pb (.clk_i, .dly_i(dly), .pb_valid_i(pb_valid_o), .pb_write_i(pb_write_o),
        .pb_addr_i(pb_addr_o), .pb_strb_i(pb_strb_o), .pb_wdata_i(pb_wdata_o),
        .pb_rdata_o(pb_rdata_i), .pb_done_o(pb_done_i), .pb_err_o(pb_err_i));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (pb_valid_o === 1'b1) begin
        last_a <= pb_addr_o;
        last_s <= pb_strb_o;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 40) begin
            n_fail++;
            final_report();
        end
    endtask
    task automatic host(input logic w, input logic [15:0] a, input logic [7:0] d);
        int i;
        @(negedge clk_i);
        {hio_valid_i, hio_write_i, hio_addr_i, hio_wdata_i} = {1'b1, w, a, d};
        for (i = 0; i < 40 && hio_done_o !== 1'b1; i++) @(negedge clk_i);
        tmo(i);
        hr = hio_rdata_o;
        hio_valid_i = 1'b0;
    endtask
    task automatic hrd(input logic [15:0] a, input logic [7:0] e);
        host(1'b0, a, 8'h00);
        cmp("host_rdata", {24'h0, e}, {24'h0, hr});
    endtask
    task automatic miss(input logic [15:0] a);
        @(negedge clk_i);
        {hio_valid_i, hio_write_i, hio_addr_i} = {1'b1, 1'b0, a};
        repeat (8) @(negedge clk_i);
        cmp("host_claim", 32'h0, {31'h0, hio_claim_o | hio_done_o});
        hio_valid_i = 1'b0;
    endtask
    task automatic ec(input logic w, input logic [1:0] s, input logic [23:0] a, input logic [31:0] d);
        int i;
        @(negedge clk_i);
        {ec_valid_i, ec_write_i, ec_size_i, ec_addr_i, ec_wdata_i} = {1'b1, w, s, a, d};
        for (i = 0; i < 40 && ec_done_o !== 1'b1; i++) @(negedge clk_i);
        tmo(i);
        rd = ec_rdata_o;
        er = ec_err_o;
        ec_valid_i = 1'b0;
    endtask
    task automatic erd(input logic [1:0] s, input logic [23:0] a, input logic [31:0] m, input logic [31:0] e);
        ec(1'b0, s, a, 32'h0);
        cmp("ec_rdata", e, rd & m);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge clk_i);
        nrst_i = 1'b1;
        cmp("cfg_mode", 32'h0, {31'h0, cfg_mode_o});
        miss(16'h002E);
        $display("test reset done");
        ec(1'b1, 2'h2, 24'hFF3360, 32'h8000002E);
        erd(2'h0, 24'hFF3360, 32'hFF, 32'h2E);
        ec(1'b1, 2'h2, 24'hFF3384, 32'hFFFFFFFF);
        erd(2'h2, 24'hFF3384, 32'hFFFFFFFF, 32'h80000000);
        erd(2'h2, 24'hFF33F0, 32'hFFFFFFFF, 32'h0);
        foreach (bad[k]) begin
            ec(1'b1, bad[k][25:24], bad[k][23:0], 32'hFFFFFFFF);
            cmp("ec_err", 32'h1, {31'h0, er});
        end
        erd(2'h2, 24'hFF3360, 32'hFFFFFFFF, 32'h8000002E);
        $display("test controller done");
        miss(16'h0030);
        host(1'b1, 16'h002F, 8'h12);
        hrd(16'h002F, 8'hFF);
        hrd(16'h002E, 8'hFF);
        host(1'b1, 16'h002E, 8'h55);
        cmp("cfg_mode", 32'h1, {31'h0, cfg_mode_o});
        hrd(16'h002E, 8'h00);
        host(1'b1, 16'h002E, 8'h07);
        host(1'b1, 16'h002F, 8'h02);
        hrd(16'h002F, 8'h02);
        erd(2'h2, 24'hFFFF04, 32'h7F000000, 32'h02000000);
        host(1'b1, 16'h002E, 8'h31);
        dly = 4'h0;
        host(1'b1, 16'h002F, 8'hA5);
        cmp("pb_addr", 32'hFF0B31, {8'h0, last_a});
        cmp("pb_strb", 32'h2, {28'h0, last_s});
        dly = 4'h5;
        hrd(16'h002F, 8'hA5);
        erd(2'h2, 24'hFF0B30, 32'hFF00, 32'hA500);
        ec(1'b1, 2'h1, 24'hFF0B32, 32'hBEEF0000);
        erd(2'h0, 24'hFF0B33, 32'hFF000000, 32'hBE000000);
        $display("test select done");
        host(1'b1, 16'h002E, 8'h05);
        host(1'b1, 16'h002F, 8'h3C);
        cmp("pb_addr", 32'hFFFF05, {8'h0, last_a});
        host(1'b1, 16'h002E, 8'h07);
        host(1'b1, 16'h002F, 8'h09);
        host(1'b1, 16'h002E, 8'h40);
        hrd(16'h002F, 8'hFF);
        host(1'b1, 16'h002F, 8'h77);
        cmp("pb_addr", 32'hFFFF05, {8'h0, last_a});
        host(1'b1, 16'h002E, 8'h07);
        host(1'b1, 16'h002F, 8'h40);
        host(1'b1, 16'h002E, 8'h32);
        hrd(16'h002F, 8'hEF);
        cmp("pb_addr", 32'hFE0332, {8'h0, last_a});
        host(1'b1, 16'h002E, 8'h07);
        host(1'b1, 16'h002F, 8'h0D);
        host(1'b1, 16'h002E, 8'h50);
        hrd(16'h002F, 8'hFF);
        $display("test units done");
        host(1'b1, 16'h002E, 8'hAA);
        cmp("cfg_mode", 32'h0, {31'h0, cfg_mode_o});
        hrd(16'h002F, 8'hFF);
        $display("test exit done");
        final_report();
    end
endmodule // tb_csd_decoder
`default_nettype wire
